//--- acr_regs.svh
/*
  Constants of the converter configuration register bank: select codes,
  field positions, reset values and synchroniser depth.
  Assumes it is included by bare name wherever the fields are decoded.
*/
`ifndef ACR_REGS_SVH
`define ACR_REGS_SVH

// Select codes on {register_select_high, register_select_low}
`define ACR_SEL_FIRST        2'h0
`define ACR_SEL_SECOND       2'h1

// Written word layout
`define ACR_WORD_W           12
`define ACR_DATA_W           10
`define ACR_SEL_MSB          11
`define ACR_SEL_LSB          10

// First control word fields
`define ACR_CW0_REFSEL       0
`define ACR_CW0_RSVD         1
`define ACR_CW0_PWRDN        2
`define ACR_CW0_CFG_LSB      3
`define ACR_CW0_CFG_MSB      7
`define ACR_CW0_TEST_LSB     8
`define ACR_CW0_TEST_MSB     9
`define ACR_CW0_RESET_VAL    10'h020

// Input configuration codes, bits 7..3 of the first word
`define ACR_CFG_POS          5'h00
`define ACR_CFG_NEG          5'h01
`define ACR_CFG_DIFF         5'h04
`define ACR_CFG_SCAN         5'h11

// Second control word fields
`define ACR_CW1_RESET        0
`define ACR_CW1_SRST         1
`define ACR_CW1_RW           6
`define ACR_CW1_BIN          7
`define ACR_CW1_OFFSET       8
`define ACR_CW1_RESET_VAL    10'h030

// Pin synchroniser
`define ACR_SYNC_STAGES      2
`define ACR_PIN_W            16
`define ACR_PIN_IDLE         16'hb000

`endif

//--- acr_pkg.sv
/*
  Types of the converter configuration register bank.
  Assumes nothing of its surroundings; used by scoped names only.
*/
package acr_pkg;

  // Host strobe state, one-hot
  typedef enum logic [2:0] {
    acr_st_idle  = 3'h1,
    acr_st_write = 3'h2,
    acr_st_read  = 3'h4
  } acr_state_t;

  // Decoded input configuration, one-hot
  typedef enum logic [4:0] {
    acr_in_pos  = 5'h01,
    acr_in_neg  = 5'h02,
    acr_in_diff = 5'h04,
    acr_in_scan = 5'h08,
    acr_in_rsvd = 5'h10
  } acr_input_t;

endpackage : acr_pkg

//--- acr_sync.sv
/*
  Two flip-flop synchroniser for a bundle of asynchronous pins.
  Assumes each bit is a slow level; multi-bit coherence comes from the host
  holding data stable around its strobe.
*/
`timescale 1ns/100ps

module acr_sync #(
  parameter int              WIDTH     = 16,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  // Clock and reset
  input  wire logic             mclk_i,
  input  wire logic             resetn_i,
  // Pins in, synchronised out
  input  wire logic [WIDTH-1:0] pins_i,
  output logic      [WIDTH-1:0] pins_o
);

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;

  // First stage feeds only the second stage
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      meta_reg <= RESET_VAL;
      sync_reg <= RESET_VAL;
    end else begin
      meta_reg <= pins_i;
      sync_reg <= meta_reg;
    end
  end

  assign pins_o = sync_reg;

endmodule : acr_sync

//--- acr_config_regs.sv
/*
  Write-only configuration register bank of a two-input pipelined converter,
  reached over the parallel host port with two chip selects, write and read.
  Assumes the host holds data and select code stable while its write strobe
  is active, and that conversion data and the conversion tick come from
  logic on mclk_i.
*/
`timescale 1ns/100ps
`include "acr_regs.svh"

module acr_config_regs (
  // Clock and reset
  input  wire logic                     mclk_i,
  input  wire logic                     resetn_i,
  // Host port pins
  input  wire logic                     chip_select_active_low_n_i,
  input  wire logic                     chip_select_active_high_i,
  input  wire logic                     wr_n_i,
  input  wire logic                     rd_n_i,
  input  wire logic                     register_select_low_i,
  input  wire logic                     register_select_high_i,
  input  wire logic [`ACR_DATA_W-1:0]   data_i,
  output logic      [`ACR_DATA_W-1:0]   data_o,
  output logic                          data_oe_o,
  // Conversion side
  input  wire logic                     conv_tick_i,
  input  wire logic [`ACR_DATA_W-1:0]   conv_data_i,
  // First word controls
  output logic                          reference_external_o,
  output logic                          power_down_o,
  output acr_pkg::acr_input_t           input_mode_o,
  output logic                          scan_negative_o,
  output logic      [1:0]               test_source_o,
  // Second word controls
  output logic                          device_reset_o,
  output logic                          sync_reset_o,
  output logic                          rw_combined_o,
  output logic                          output_binary_o,
  output logic                          offset_cal_o
);

  // Decode of bits 7..3 of the first word
  function automatic acr_pkg::acr_input_t decode_input(input logic [4:0] cfg);
    acr_pkg::acr_input_t mode;
    mode = acr_pkg::acr_in_rsvd;
    case (cfg)
      `ACR_CFG_POS:  mode = acr_pkg::acr_in_pos;
      `ACR_CFG_NEG:  mode = acr_pkg::acr_in_neg;
      `ACR_CFG_DIFF: mode = acr_pkg::acr_in_diff;
      `ACR_CFG_SCAN: mode = acr_pkg::acr_in_scan;
      default:       mode = acr_pkg::acr_in_rsvd;
    endcase
    return mode;
  endfunction : decode_input

  logic [`ACR_PIN_W-1:0]   pins_raw;
  logic [`ACR_PIN_W-1:0]   pins_s;
  logic                    cs_low_n_s;
  logic                    cs_high_s;
  logic                    wr_n_s;
  logic                    rd_n_s;
  logic [`ACR_WORD_W-1:0]  bus_word;
  logic                    chip_sel;
  logic                    wr_act;
  logic                    rd_act;
  logic                    commit;
  logic [1:0]              commit_sel;
  acr_pkg::acr_state_t     state_reg;
  acr_pkg::acr_state_t     state_next;
  logic [`ACR_WORD_W-1:0]  word_reg;
  logic [`ACR_DATA_W-1:0]  cw0_reg;
  logic [`ACR_DATA_W-1:0]  cw1_reg;
  acr_pkg::acr_input_t     input_mode_reg;
  logic                    scan_neg_reg;
  logic [`ACR_DATA_W-1:0]  data_out_reg;
  logic                    data_oe_reg;

  // Every host pin crosses into mclk_i through two flip-flops
  assign pins_raw = {chip_select_active_low_n_i, chip_select_active_high_i, wr_n_i, rd_n_i,
                     register_select_high_i, register_select_low_i, data_i};

  acr_sync #(
    .WIDTH     (`ACR_PIN_W),
    .RESET_VAL (`ACR_PIN_IDLE)
  ) u_pin_sync (
    .mclk_i   (mclk_i),
    .resetn_i (resetn_i),
    .pins_i   (pins_raw),
    .pins_o   (pins_s)
  );

  // Unpack the synchronised pins
  assign cs_low_n_s = pins_s[15];
  assign cs_high_s  = pins_s[14];
  assign wr_n_s     = pins_s[13];
  assign rd_n_s     = pins_s[12];
  assign bus_word   = pins_s[`ACR_WORD_W-1:0];

  // internal strobes
  // The last input to become valid opens a strobe, the first to drop ends it.
  // In combined mode the write pin carries the direction and read is unused.
  assign chip_sel = !cs_low_n_s && cs_high_s;
  always_comb begin
    if (cw1_reg[`ACR_CW1_RW]) begin
      wr_act = chip_sel && !wr_n_s;
      rd_act = chip_sel && wr_n_s;
    end else begin
      wr_act = chip_sel && !wr_n_s && rd_n_s;
      rd_act = chip_sel && !rd_n_s && wr_n_s;
    end
  end

  // Strobe state machine
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      acr_pkg::acr_st_idle: begin
        if (wr_act) begin
          state_next = acr_pkg::acr_st_write;
        end else if (rd_act) begin
          state_next = acr_pkg::acr_st_read;
        end
      end
      acr_pkg::acr_st_write: begin
        if (!wr_act) begin
          state_next = acr_pkg::acr_st_idle;
        end
      end
      acr_pkg::acr_st_read: begin
        if (!rd_act) begin
          state_next = acr_pkg::acr_st_idle;
        end
      end
      default: state_next = acr_pkg::acr_st_idle;
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      state_reg <= acr_pkg::acr_st_idle;
    end else begin
      state_reg <= state_next;
    end
  end

  // word capture
  // Sampled on every write strobe cycle so the last stable word is committed
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      word_reg <= '0;
    end else if (wr_act) begin
      word_reg <= bus_word;
    end
  end

  // Commit at the end of the strobe, when the word has settled
  assign commit     = (state_reg == acr_pkg::acr_st_write) && !wr_act;
  assign commit_sel = word_reg[`ACR_SEL_MSB:`ACR_SEL_LSB];

  // first word store, reset value
  // While the second word holds the device in reset the first stays at reset.
  // Unused select codes are ignored.
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      cw0_reg <= `ACR_CW0_RESET_VAL;
    end else if (commit && commit_sel == `ACR_SEL_SECOND && word_reg[`ACR_CW1_RESET]) begin
      cw0_reg <= `ACR_CW0_RESET_VAL;
    end else if (commit && commit_sel == `ACR_SEL_FIRST && !cw1_reg[`ACR_CW1_RESET]) begin
      cw0_reg <= word_reg[`ACR_DATA_W-1:0];
    end
  end

  // second word store
  // A reset request restores all fields but keeps the reset bit itself
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      cw1_reg <= `ACR_CW1_RESET_VAL;
    end else if (commit && commit_sel == `ACR_SEL_SECOND) begin
      if (word_reg[`ACR_CW1_RESET]) begin
        cw1_reg <= `ACR_CW1_RESET_VAL | 10'h001;
      end else begin
        cw1_reg <= word_reg[`ACR_DATA_W-1:0];
      end
    end
  end

  // input decode
  // Reserved codes map to their own state rather than a valid one
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      input_mode_reg <= acr_pkg::acr_in_diff;
    end else begin
      input_mode_reg <= decode_input(cw0_reg[`ACR_CW0_CFG_MSB:`ACR_CW0_CFG_LSB]);
    end
  end

  // autoscan alternation
  // Starts on the positive input and flips on each conversion tick
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      scan_neg_reg <= 1'b0;
    end else if (input_mode_reg != acr_pkg::acr_in_scan) begin
      scan_neg_reg <= 1'b0;
    end else if (conv_tick_i) begin
      scan_neg_reg <= !scan_neg_reg;
    end
  end

  // read path
  // Not gated by power down, so the port stays usable while the core sleeps
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      data_oe_reg  <= 1'b0;
      data_out_reg <= '0;
    end else begin
      data_oe_reg <= rd_act;
      if (rd_act) begin
        data_out_reg <= conv_data_i;
      end
    end
  end

  assign reference_external_o = cw0_reg[`ACR_CW0_REFSEL];
  assign power_down_o         = cw0_reg[`ACR_CW0_PWRDN];
  assign test_source_o        = cw0_reg[`ACR_CW0_TEST_MSB:`ACR_CW0_TEST_LSB];
  assign input_mode_o         = input_mode_reg;
  assign scan_negative_o      = scan_neg_reg;

  // Second word outputs
  assign device_reset_o  = cw1_reg[`ACR_CW1_RESET];
  assign sync_reset_o    = cw1_reg[`ACR_CW1_SRST];
  assign rw_combined_o   = cw1_reg[`ACR_CW1_RW];
  assign output_binary_o = cw1_reg[`ACR_CW1_BIN];
  assign offset_cal_o    = cw1_reg[`ACR_CW1_OFFSET];

  // Host data bus
  assign data_o    = data_out_reg;
  assign data_oe_o = data_oe_reg;

  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!resetn_i);

  // Write strobe opening and closing
  sequence s_write_open;
    (state_reg == acr_pkg::acr_st_idle && wr_act) ##1 (state_reg == acr_pkg::acr_st_write);
  endsequence

  sequence s_write_close;
    (state_reg == acr_pkg::acr_st_write && !wr_act);
  endsequence

  AST_WRITE_OPEN: assert property (s_write_open |=>
      (state_reg == acr_pkg::acr_st_write) == $past(wr_act))
    else $error("write strobe state wrong after opening");

  AST_WRITE_STROBE: assert property (s_write_close |=>
      state_reg == acr_pkg::acr_st_idle)
    else $error("write strobe did not close to idle");

  AST_READ_BLOCKS_WRITE: assert property ((!rw_combined_o && !rd_n_s &&
      state_reg == acr_pkg::acr_st_idle) |=> state_reg != acr_pkg::acr_st_write)
    else $error("write accepted while read active");

  AST_FIRST_WORD: assert property ((commit && commit_sel == `ACR_SEL_FIRST &&
      !cw1_reg[`ACR_CW1_RESET]) |=> cw0_reg == $past(word_reg[`ACR_DATA_W-1:0]))
    else $error("first word not stored");

  AST_SECOND_WORD: assert property ((commit && commit_sel == `ACR_SEL_SECOND &&
      !word_reg[`ACR_CW1_RESET]) |=> cw1_reg == $past(word_reg[`ACR_DATA_W-1:0]))
    else $error("second word not stored");

  AST_RESET_FIELDS: assert property ($rose(resetn_i) |->
      (!reference_external_o && !power_down_o && test_source_o == 2'h0))
    else $error("reference, power down or test not zero after reset");

  AST_RESET_CFG: assert property ($rose(resetn_i) |->
      cw0_reg[`ACR_CW0_CFG_MSB:`ACR_CW0_CFG_LSB] == 5'h04)
    else $error("configuration field not 00100 after reset");

  AST_PD_READ: assert property ((power_down_o && rd_act) |=> data_oe_o)
    else $error("read refused in power down");

  AST_POWER_DOWN: assert property ((commit && commit_sel == `ACR_SEL_FIRST &&
      !cw1_reg[`ACR_CW1_RESET]) |=> power_down_o == $past(word_reg[`ACR_CW0_PWRDN]))
    else $error("power down bit not taken");

  AST_TEST_SOURCE: assert property ((commit && commit_sel == `ACR_SEL_FIRST &&
      !cw1_reg[`ACR_CW1_RESET]) |=> test_source_o == $past(word_reg[9:8]))
    else $error("test source not taken");

  AST_DECODE_POS: assert property ((cw0_reg[7:3] == 5'h00) |=>
      input_mode_o == acr_pkg::acr_in_pos)
    else $error("positive input not decoded");

  AST_DECODE_NEG: assert property ((cw0_reg[7:3] == 5'h01) |=>
      input_mode_o == acr_pkg::acr_in_neg)
    else $error("negative input not decoded");

  AST_DECODE_DIFF: assert property ((cw0_reg[7:3] == 5'h04) |=>
      input_mode_o == acr_pkg::acr_in_diff)
    else $error("differential pair not decoded");

  AST_SCAN_TOGGLE: assert property ((input_mode_o == acr_pkg::acr_in_scan &&
      conv_tick_i) |=> scan_negative_o != $past(scan_negative_o))
    else $error("autoscan did not alternate");

endmodule : acr_config_regs

//--- acr_host_model.sv
/*
  Behavioural host processor on the parallel port of the configuration bank.
  Assumes the bench calls its tasks and that mclk_i is the bank clock.
*/
`timescale 1ns/100ps
`include "acr_regs.svh"

module acr_host_model (
  // Clock and bus answer
  input  wire logic                   mclk_i,
  input  wire logic [`ACR_DATA_W-1:0] rd_data_i,
  input  wire logic                   rd_oe_i,
  // Host pins
  output logic                        cs_low_n_o,
  output logic                        cs_high_o,
  output logic                        wr_n_o,
  output logic                        rd_n_o,
  output logic                        sel_low_o,
  output logic                        sel_high_o,
  output logic [`ACR_DATA_W-1:0]      wdata_o
);
  // Idle pins at time zero
  initial begin
    cs_low_n_o = 1'b1;
    cs_high_o  = 1'b0;
    wr_n_o     = 1'b1;
    rd_n_o     = 1'b1;
    sel_low_o  = 1'b0;
    sel_high_o = 1'b0;
    wdata_o    = 10'h000;
  end

  // Drop every strobe and leave three idle clocks or more
  task automatic release_bus();
    cs_low_n_o <= 1'b1;
    cs_high_o  <= 1'b0;
    wr_n_o     <= 1'b1;
    rd_n_o     <= 1'b1;
    repeat (6) @(posedge mclk_i);
  endtask : release_bus

  // One write; rd_low or cs_off break the strobe on purpose
  task automatic write_word(input logic [11:0] word, input logic rd_low, input logic cs_off);
    @(posedge mclk_i);
    {sel_high_o, sel_low_o, wdata_o} <= word;
    cs_low_n_o <= 1'b0;
    cs_high_o  <= ~cs_off;
    wr_n_o     <= 1'b0;
    rd_n_o     <= ~rd_low;
    // data held through the whole strobe
    repeat (4) @(posedge mclk_i);
    // Released lines must not keep showing the written value
    wdata_o <= ~word[9:0];
    release_bus();
  endtask : write_word

  // One read; answer taken at the edge where the strobe ends
  task automatic read_word(output logic [9:0] data, output logic oe);
    @(posedge mclk_i);
    cs_low_n_o <= 1'b0;
    cs_high_o  <= 1'b1;
    rd_n_o     <= 1'b0;
    repeat (5) @(posedge mclk_i);
    data = rd_data_i;
    oe   = rd_oe_i;
    release_bus();
  endtask : read_word
endmodule : acr_host_model

//--- acr_config_regs_bench.sv
/*
  Self-checking bench of the configuration register bank with a host model.
  Assumes the host model holds strobes long enough for the pin synchroniser.
*/
`timescale 1ns/100ps
`include "acr_regs.svh"

module acr_config_regs_bench;
  logic                     mclk_i = 1'b0;
  logic                     resetn_i = 1'b0;
  logic                     cs_low_n, cs_high, wr_n, rd_n, sel_low, sel_high;
  logic [`ACR_DATA_W-1:0]   wdata, data_o;
  logic                     data_oe_o;
  logic                     conv_tick_i = 1'b0;
  logic [`ACR_DATA_W-1:0]   conv_data_i = 10'h000;
  logic                     reference_external_o, power_down_o, scan_negative_o;
  acr_pkg::acr_input_t      input_mode_o;
  logic [1:0]               test_source_o;
  logic                     device_reset_o, sync_reset_o, rw_combined_o;
  logic                     output_binary_o, offset_cal_o;
  logic [9:0]               fw_view, sw_view, rdat;
  logic                     roe;
  int                       err_count = 0;
  int                       cmp_count = 0;
  int                       cycle_count = 0;

  // Packed views of the decoded controls
  assign fw_view = {6'h00, test_source_o, power_down_o, reference_external_o};
  assign sw_view = {5'h00, device_reset_o, sync_reset_o, rw_combined_o,
                    output_binary_o, offset_cal_o};

  always #12.5 mclk_i = ~mclk_i;

  acr_config_regs acr_config_regs_inst (
    .mclk_i(mclk_i), .resetn_i(resetn_i),
    .chip_select_active_low_n_i(cs_low_n), .chip_select_active_high_i(cs_high),
    .wr_n_i(wr_n), .rd_n_i(rd_n), .register_select_low_i(sel_low),
    .register_select_high_i(sel_high), .data_i(wdata), .data_o(data_o),
    .data_oe_o(data_oe_o), .conv_tick_i(conv_tick_i), .conv_data_i(conv_data_i),
    .reference_external_o(reference_external_o), .power_down_o(power_down_o),
    .input_mode_o(input_mode_o), .scan_negative_o(scan_negative_o),
    .test_source_o(test_source_o), .device_reset_o(device_reset_o),
    .sync_reset_o(sync_reset_o), .rw_combined_o(rw_combined_o),
    .output_binary_o(output_binary_o), .offset_cal_o(offset_cal_o));

  acr_host_model acr_host_model_inst (
    .mclk_i(mclk_i), .rd_data_i(data_o), .rd_oe_i(data_oe_o),
    .cs_low_n_o(cs_low_n), .cs_high_o(cs_high), .wr_n_o(wr_n), .rd_n_o(rd_n),
    .sel_low_o(sel_low), .sel_high_o(sel_high), .wdata_o(wdata));

  task automatic check_vec(input logic [9:0] got, input logic [9:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check_vec

  task automatic check_mode(input acr_pkg::acr_input_t got, input acr_pkg::acr_input_t exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: input mode %h expected %h", $time, got, exp);
    end
  endtask : check_mode

  task automatic wr(input logic [11:0] word);
    acr_host_model_inst.write_word(word, 1'b0, 1'b0);
    @(negedge mclk_i);
  endtask : wr

  task automatic test_reset();
    check_vec(fw_view, 10'h000, "first word outputs");
    check_mode(input_mode_o, acr_pkg::acr_in_diff);
    check_vec(sw_view, 10'h000, "second word outputs");
    check_vec({9'h000, data_oe_o}, 10'h000, "bus drive idle");
    $display("Test reset done");
  endtask : test_reset

  task automatic test_config();
    logic [4:0]          codes [5];
    acr_pkg::acr_input_t modes [5];
    codes = '{`ACR_CFG_POS, `ACR_CFG_NEG, `ACR_CFG_DIFF, `ACR_CFG_SCAN, 5'h02};
    modes = '{acr_pkg::acr_in_pos, acr_pkg::acr_in_neg, acr_pkg::acr_in_diff,
              acr_pkg::acr_in_scan, acr_pkg::acr_in_rsvd};
    for (int i = 0; i < 5; i++) begin
      wr({2'h0, 2'h0, codes[i], 3'h0});
      check_mode(input_mode_o, modes[i]);
    end
    // Scan begins on the positive input and steps on each tick
    wr({4'h0, `ACR_CFG_SCAN, 3'h0});
    check_vec({9'h000, scan_negative_o}, 10'h000, "scan start");
    @(posedge mclk_i) conv_tick_i <= 1'b1;
    @(posedge mclk_i) conv_tick_i <= 1'b0;
    @(negedge mclk_i);
    check_vec({9'h000, scan_negative_o}, 10'h001, "scan step");
    $display("Test config done");
  endtask : test_config

  task automatic test_fields();
    logic [1:0] t;
    for (int i = 0; i < 4; i++) begin
      t = i[1:0];
      wr({2'h0, t, `ACR_CFG_DIFF, 2'h0, t[0]});
      check_vec(fw_view, {6'h00, t, 1'b0, t[0]}, "test and reference");
    end
    $display("Test fields done");
  endtask : test_fields

  task automatic test_power();
    wr({2'h0, 10'h025});
    check_vec(fw_view, 10'h003, "power down");
    @(posedge mclk_i) conv_data_i <= 10'h2a5;
    acr_host_model_inst.read_word(rdat, roe);
    check_vec({9'h000, roe}, 10'h001, "read drive in power down");
    check_vec(rdat, 10'h2a5, "read data in power down");
    wr({2'h0, 10'h020});
    check_vec(fw_view, 10'h000, "write in power down");
    $display("Test power done");
  endtask : test_power

  task automatic test_second();
    wr({`ACR_SEL_SECOND, 10'h1c2});
    check_vec(sw_view, 10'h00f, "second word");
    // Combined mode: a high write pin with both selects is a read
    acr_host_model_inst.read_word(rdat, roe);
    check_vec({9'h000, roe}, 10'h001, "combined read drive");
    check_vec(rdat, 10'h2a5, "combined read data");
    // Unused select codes must touch neither word
    wr({2'h2, 10'h3ff});
    wr({2'h3, 10'h3ff});
    check_vec(sw_view, 10'h00f, "reserved code second");
    check_vec(fw_view, 10'h000, "reserved code first");
    // Device reset restores both words and holds the first one
    wr({`ACR_SEL_FIRST, 10'h025});
    wr({`ACR_SEL_SECOND, 10'h001});
    check_vec(sw_view, 10'h010, "device reset");
    check_vec(fw_view, 10'h000, "first word after device reset");
    check_mode(input_mode_o, acr_pkg::acr_in_diff);
    wr({`ACR_SEL_FIRST, 10'h025});
    check_vec(fw_view, 10'h000, "first word held in device reset");
    wr({`ACR_SEL_SECOND, 10'h000});
    check_vec(sw_view, 10'h000, "second word cleared");
    $display("Test second done");
  endtask : test_second

  task automatic test_strobe();
    acr_host_model_inst.write_word({2'h0, 10'h004}, 1'b1, 1'b0);
    @(negedge mclk_i);
    check_vec(fw_view, 10'h000, "write with read low");
    acr_host_model_inst.write_word({2'h0, 10'h004}, 1'b0, 1'b1);
    @(negedge mclk_i);
    check_vec(fw_view, 10'h000, "write without select");
    wr({2'h0, 10'h004});
    check_vec(fw_view, 10'h002, "full strobe");
    $display("Test strobe done");
  endtask : test_strobe

  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : report_and_stop

  // Hang guard, well above the few hundred cycles the tests need
  always @(posedge mclk_i) begin
    cycle_count <= cycle_count + 1;
    if (cycle_count == 3000) begin
      err_count++;
      $display("CHECK FAILED at %0t: timeout", $time);
      report_and_stop();
    end
  end

  // Synchronous reset held low for two edges loads the idle pin value into both synchroniser stages
  initial begin
    repeat (2) @(posedge mclk_i);
    resetn_i <= 1'b1;
    @(negedge mclk_i);
    test_reset();
    test_config();
    test_fields();
    test_power();
    test_second();
    test_strobe();
    report_and_stop();
  end
endmodule : acr_config_regs_bench
